// ### hw/clp_parser.v
`timescale 1ns/1ps
`default_nettype none
`include "clp_defs.vh"

module clp_parser (
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    // incoming bytes
    input wire rx_valid,
    input wire [7:0] rx_data,
    // display controller write port, one entry per write
    output wire lcd_valid,
    input wire lcd_ready,
    output wire [7:0] lcd_data,
    // glyph bitmap write
    output reg glyph_we_q,
    output reg [2:0] glyph_idx_q,
    output reg [2:0] glyph_row_q,
    output reg [5:0] glyph_bits_q,
    // display actions
    output reg scroll_up_q,
    output reg info_show_q,
    output reg reboot_q,
    // status
    output reg [4:0] cursor_col_q,
    output reg [1:0] cursor_row_q,
    output reg wrap_en_q,
    output reg scroll_en_q,
    output reg overflow_q
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam ST_IDLE = 6'b000001;
    localparam ST_GLYPH = 6'b000010;
    localparam ST_DIRECT = 6'b000100;
    localparam ST_ESC = 6'b001000;
    localparam ST_ESC_BR = 6'b010000;
    localparam ST_REBOOT = 6'b100000;

    reg [5:0] state_q;
    reg [3:0] pend_q;
    reg [7:0] loc_q;
    reg [2:0] gidx_q;

    // ----------------------------------------
    // input queue and output fifo
    // ----------------------------------------
    wire q_valid;
    wire [7:0] q_data;
    wire q_ready;
    wire q_ovf;
    reg f_valid;
    reg [9:0] f_data;
    wire f_ready;
    wire [9:0] f_out;
    wire f_out_valid;
    wire f_pop;

    clp_inbuf u_inbuf (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(rx_valid),
        .in_data(rx_data),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_data),
        .overflow_q(q_ovf)
    );

    // fifo word: {ctrl_extended_enable, ctrl_reg_select, data}
    clp_fifo #(.WIDTH(10), .DEPTH(`CLP_FIFO_DEPTH), .AW(`CLP_FIFO_AW)) u_fifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(f_valid),
        .in_ready(f_ready),
        .in_data(f_data),
        .out_valid(f_out_valid),
        .out_ready(f_pop),
        .out_data(f_out)
    );

    // ----------------------------------------
    // output register stage
    // ----------------------------------------
    // controller register selects ride along with each word
    reg lcd_valid_q;
    reg [7:0] lcd_data_q;
    reg ctrl_reg_select_q;
    reg ctrl_extended_enable_q;

    // the stage reloads whenever it is empty or its word is being taken
    assign f_pop = !lcd_valid_q || lcd_ready;
    assign lcd_valid = lcd_valid_q;
    assign lcd_data = lcd_data_q;

    always @(posedge clk_sys) begin
        if (!resetn) begin
            lcd_valid_q <= 1'b0;
            lcd_data_q <= 8'h00;
            ctrl_reg_select_q <= 1'b0;
            ctrl_extended_enable_q <= 1'b0;
        end else if (f_pop) begin
            lcd_valid_q <= f_out_valid;
            lcd_data_q <= f_out[7:0];
            ctrl_reg_select_q <= f_out[8];
            ctrl_extended_enable_q <= f_out[9];
        end
    end

    // no take while a word is in flight, so a word never meets a fifo that just filled
    assign q_ready = f_ready && !f_valid;
    wire take = q_valid && q_ready;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function is_ctrl;
        input [7:0] b;
        begin
            is_ctrl = (b <= `CLP_CTRL_LAST);
        end
    endfunction

    function [7:0] glyph_code;
        input [7:0] b;
        begin
            if (b >= `CLP_USER_FIRST && b <= `CLP_USER_LAST) begin
                glyph_code = {5'b0, b[2:0]};
            end else begin
                glyph_code = b;
            end
        end
    endfunction

    // location byte to {ctrl_extended_enable, ctrl_reg_select}
    function [1:0] loc_selects;
        input [7:0] loc;
        begin
            case (loc)
                `CLP_LOC_CTRL: loc_selects = 2'b00;
                `CLP_LOC_DATA: loc_selects = 2'b01;
                `CLP_LOC_CTRL_EXT: loc_selects = 2'b10;
                default: loc_selects = 2'b00;
            endcase
        end
    endfunction

    // ----------------------------------------
    // cursor geometry
    // ----------------------------------------
    wire on_screen = (cursor_col_q < `CLP_COLS);
    wire last_col = (cursor_col_q == `CLP_COLS - 5'd1);
    wire last_row = (cursor_row_q == `CLP_ROWS - 2'd1);

    // ----------------------------------------
    // parser
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            pend_q <= 4'h0;
            loc_q <= 8'h00;
            gidx_q <= 3'h0;
            f_valid <= 1'b0;
            f_data <= 10'h000;
            glyph_we_q <= 1'b0;
            glyph_idx_q <= 3'h0;
            glyph_row_q <= 3'h0;
            glyph_bits_q <= 6'h00;
            scroll_up_q <= 1'b0;
            info_show_q <= 1'b0;
            reboot_q <= 1'b0;
            cursor_col_q <= 5'h00;
            cursor_row_q <= 2'h0;
            wrap_en_q <= 1'b0;
            scroll_en_q <= 1'b1;
            overflow_q <= 1'b0;
        end else begin
            f_valid <= 1'b0;
            glyph_we_q <= 1'b0;
            scroll_up_q <= 1'b0;
            info_show_q <= 1'b0;
            reboot_q <= 1'b0;
            overflow_q <= q_ovf;
            if (take) begin
                case (state_q)
                    ST_GLYPH: begin
                        // any value here is a parameter
                        if (pend_q == `CLP_GLYPH_PARAMS) begin
                            gidx_q <= q_data[2:0];
                        end else begin
                            glyph_we_q <= 1'b1;
                            glyph_idx_q <= gidx_q;
                            glyph_row_q <= 3'd0 - pend_q[2:0]; // first byte is top row
                            glyph_bits_q <= q_data[5:0];
                        end
                        pend_q <= pend_q - 4'h1;
                        if (pend_q == 4'h1) begin
                            state_q <= ST_IDLE;
                        end
                    end
                    ST_DIRECT: begin
                        if (pend_q == `CLP_DIRECT_PARAMS) begin
                            loc_q <= q_data;
                            pend_q <= pend_q - 4'h1;
                        end else begin
                            f_valid <= 1'b1;
                            // location decode of register selects
                            f_data <= {loc_selects(loc_q), q_data};
                            pend_q <= 4'h0;
                            state_q <= ST_IDLE;
                        end
                    end
                    ST_ESC: begin
                        state_q <= (q_data == `CLP_ESC_BRACKET) ? ST_ESC_BR : ST_IDLE;
                    end
                    ST_ESC_BR: begin
                        state_q <= ST_IDLE;
                        // arrows clamp at edges, never wrap
                        case (q_data)
                            `CLP_ARROW_UP: begin
                                if (cursor_row_q != 2'h0) begin
                                    cursor_row_q <= cursor_row_q - 2'h1;
                                end
                            end
                            `CLP_ARROW_DOWN: begin
                                if (!last_row) begin
                                    cursor_row_q <= cursor_row_q + 2'h1;
                                end
                            end
                            `CLP_ARROW_RIGHT: begin
                                if (cursor_col_q < `CLP_COLS - 5'd1) begin
                                    cursor_col_q <= cursor_col_q + 5'h1;
                                end
                            end
                            `CLP_ARROW_LEFT: begin
                                if (cursor_col_q != 5'h0) begin
                                    cursor_col_q <= on_screen ? cursor_col_q - 5'h1
                                                              : `CLP_COLS - 5'd1;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                    default: begin
                        // idle or one reboot code seen
                        state_q <= ST_IDLE;
                        if (is_ctrl(q_data)) begin
                            // never shown as a glyph
                            case (q_data)
                                `CLP_CMD_WRAP_ON: begin
                                    wrap_en_q <= 1'b1;
                                end
                                `CLP_CMD_WRAP_OFF: begin
                                    wrap_en_q <= 1'b0;
                                end
                                `CLP_CMD_SCROLL_ON: begin
                                    scroll_en_q <= 1'b1;
                                end
                                `CLP_CMD_SCROLL_OFF: begin
                                    scroll_en_q <= 1'b0;
                                end
                                `CLP_CMD_CR: begin
                                    cursor_col_q <= 5'h00;
                                end
                                `CLP_CMD_GLYPH: begin
                                    state_q <= ST_GLYPH;
                                    pend_q <= `CLP_GLYPH_PARAMS;
                                end
                                `CLP_CMD_DIRECT: begin
                                    state_q <= ST_DIRECT;
                                    pend_q <= `CLP_DIRECT_PARAMS;
                                end
                                `CLP_CMD_ESC: begin
                                    state_q <= ST_ESC;
                                end
                                `CLP_CMD_INFO: begin
                                    info_show_q <= 1'b1;
                                end
                                `CLP_CMD_REBOOT: begin
                                    if (state_q == ST_REBOOT) begin
                                        // second code in a row: back to defaults
                                        reboot_q <= 1'b1;
                                        wrap_en_q <= 1'b0;
                                        scroll_en_q <= 1'b1;
                                        cursor_col_q <= 5'h00;
                                        cursor_row_q <= 2'h0;
                                    end else begin
                                        state_q <= ST_REBOOT;
                                    end
                                end
                                default: begin
                                end
                            endcase
                        end else if (on_screen) begin
                            // printable drops while off-screen
                            f_valid <= 1'b1;
                            f_data <= {loc_selects(`CLP_LOC_DATA), glyph_code(q_data)};
                            if (!last_col) begin
                                cursor_col_q <= cursor_col_q + 5'h1;
                            end else if (!wrap_en_q) begin
                                cursor_col_q <= `CLP_COL_OFF;
                            end else begin
                                cursor_col_q <= 5'h00;
                                if (!last_row) begin
                                    cursor_row_q <= cursor_row_q + 2'h1;
                                end else if (scroll_en_q) begin
                                    scroll_up_q <= 1'b1;
                                end else begin
                                    cursor_row_q <= 2'h0;
                                end
                            end
                        end
                    end
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// ### hw/clp_defs.vh
`ifndef CLP_DEFS_VH
`define CLP_DEFS_VH

// ----------------------------------------
// command codes
// ----------------------------------------
`define CLP_CMD_CR 8'h0D
`define CLP_CMD_SCROLL_ON 8'h13
`define CLP_CMD_SCROLL_OFF 8'h14
`define CLP_CMD_WRAP_ON 8'h17
`define CLP_CMD_WRAP_OFF 8'h18
`define CLP_CMD_GLYPH 8'h19
`define CLP_CMD_REBOOT 8'h1A
`define CLP_CMD_ESC 8'h1B
`define CLP_CMD_DIRECT 8'h1E
`define CLP_CMD_INFO 8'h1F
`define CLP_ESC_BRACKET 8'h5B
`define CLP_ARROW_UP 8'h41
`define CLP_ARROW_DOWN 8'h42
`define CLP_ARROW_RIGHT 8'h43
`define CLP_ARROW_LEFT 8'h44
`define CLP_CTRL_LAST 8'h1F
`define CLP_USER_FIRST 8'h80
`define CLP_USER_LAST 8'h87

// ----------------------------------------
// parameter counts and geometry
// ----------------------------------------
`define CLP_GLYPH_PARAMS 4'h9
`define CLP_DIRECT_PARAMS 4'h2
`define CLP_COLS 5'h10
`define CLP_ROWS 2'h2
`define CLP_COL_OFF 5'h10
`define CLP_ROW_MAX 6'h3F

// ----------------------------------------
// direct-write locations
// ----------------------------------------
`define CLP_LOC_CTRL 8'h00
`define CLP_LOC_DATA 8'h01
`define CLP_LOC_CTRL_EXT 8'h02

// ----------------------------------------
// buffering
// ----------------------------------------
`define CLP_FIFO_DEPTH 8
`define CLP_FIFO_AW 3
`define CLP_INBUF_DEPTH 64

`endif

// ### hw/clp_fifo.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// small synchronous fifo, valid/ready on both sides
// ----------------------------------------
module clp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge clk_sys) begin
        if (!resetn) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ### hw/clp_inbuf.v
`timescale 1ns/1ps
`default_nettype none
`include "clp_defs.vh"

// ----------------------------------------
// 64-byte input queue; on overflow the newest byte replaces the oldest
// ----------------------------------------
module clp_inbuf (
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    // byte arrival
    input wire in_valid,
    input wire [7:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [7:0] out_data,
    // status
    output reg overflow_q
);
    reg [7:0] mem [0:`CLP_INBUF_DEPTH-1];
    reg [5:0] wr_q;
    reg [5:0] rd_q;
    reg [6:0] cnt_q;
    wire full;
    wire pop;

    assign full = (cnt_q == 7'd64);
    assign out_valid = (cnt_q != 7'd0);
    assign out_data = mem[rd_q];
    assign pop = out_valid && out_ready;

    always @(posedge clk_sys) begin
        if (in_valid) begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge clk_sys) begin
        if (!resetn) begin
            wr_q <= 6'd0;
            rd_q <= 6'd0;
            cnt_q <= 7'd0;
            overflow_q <= 1'b0;
        end else begin
            overflow_q <= in_valid && full && !pop;
            if (in_valid) begin
                wr_q <= wr_q + 6'd1;
            end
            // full and no drain: oldest byte is dropped by advancing read side
            if (pop || (in_valid && full)) begin
                rd_q <= rd_q + 6'd1;
            end
            if (in_valid && !full && !pop) begin
                cnt_q <= cnt_q + 7'd1;
            end else if (pop && !in_valid) begin
                cnt_q <= cnt_q - 7'd1;
            end
        end
    end
endmodule

`default_nettype wire

// ### sim/clp_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module clp_monitor (
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    // controller port
    input wire lcd_valid,
    input wire lcd_ready,
    input wire [7:0] lcd_data,
    // glyph and actions
    input wire glyph_we_q,
    input wire [2:0] glyph_row_q,
    input wire scroll_up_q,
    input wire reboot_q,
    input wire overflow_q,
    // status
    input wire [4:0] cursor_col_q,
    input wire [1:0] cursor_row_q,
    input wire wrap_en_q,
    input wire scroll_en_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_reset_state: assert property (disable iff (1'b0) !resetn |=>
        cursor_col_q == 5'h0 && cursor_row_q == 2'h0 && scroll_en_q && !reboot_q)
        else $error("state not at defaults after reset");
    a_col_range: assert property (cursor_col_q <= 5'h10)
        else $error("cursor column beyond off-screen");
    a_row_range: assert property (cursor_row_q <= 2'h1)
        else $error("cursor row beyond bottom");
    a_glyph_order: assert property (glyph_we_q && glyph_row_q != 3'h7 |=>
        !glyph_we_q || glyph_row_q == $past(glyph_row_q) + 3'h1)
        else $error("glyph rows out of order");
    a_scroll_cause: assert property (scroll_up_q |-> wrap_en_q && scroll_en_q &&
        cursor_row_q == 2'h1 && cursor_col_q == 5'h0)
        else $error("scroll without wrap at bottom");
    a_col_step: assert property ($past(resetn) && cursor_col_q != $past(cursor_col_q) |->
        cursor_col_q == 5'h0 || cursor_col_q == $past(cursor_col_q) + 5'h1 ||
        cursor_col_q + 5'h1 == $past(cursor_col_q))
        else $error("cursor column jumped");
    a_reboot_state: assert property (reboot_q |-> ##[0:1]
        (cursor_col_q == 5'h0 && cursor_row_q == 2'h0 && !wrap_en_q && scroll_en_q))
        else $error("reboot left state changed");
    a_reboot_once: assert property (reboot_q |=> !reboot_q)
        else $error("reboot pulse repeated");
    a_lcd_hold: assert property (lcd_valid && !lcd_ready |=> lcd_valid && $stable(lcd_data))
        else $error("controller word dropped while stalled");

    c_scroll: cover property (scroll_up_q);
    c_glyph: cover property (glyph_we_q && glyph_row_q == 3'h7);
    c_reboot: cover property (reboot_q);
    c_overflow: cover property (overflow_q);
endmodule

`default_nettype wire

// ### sim/clp_lcd_sink.sv
`timescale 1ns/1ps
`default_nettype none

module clp_lcd_sink (
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    // controller write port
    input wire lcd_valid,
    output logic lcd_ready,
    input wire [7:0] lcd_data,
    // test control and record
    input wire hold,
    output logic [15:0] n_words,
    output logic [7:0] last_word
);
    // random stalls; hold keeps the sink refusing
    always @(posedge clk_sys) begin
        if (!resetn) begin
            lcd_ready <= 1'b0;
            n_words <= 16'h0;
            last_word <= 8'h00;
        end else begin
            if (lcd_valid && lcd_ready) begin
                n_words <= n_words + 16'h1;
                last_word <= lcd_data;
            end
            lcd_ready <= !hold && ($urandom % 4 != 0);
        end
    end
endmodule

`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end

module tb;
    logic clk_sys, resetn, rx_valid, hold;
    logic [7:0] rx_data, d;
    wire lcd_valid, lcd_ready, glyph_we_q, scroll_up_q, info_show_q, reboot_q;
    wire wrap_en_q, scroll_en_q, overflow_q;
    wire [7:0] lcd_data, last_word;
    wire [2:0] glyph_idx_q, glyph_row_q;
    wire [5:0] glyph_bits_q;
    wire [4:0] cursor_col_q;
    wire [1:0] cursor_row_q;
    wire [15:0] n_words;
    int mismatches = 0;
    int n_checks = 0;
    int n_scr = 0, n_rbt = 0, n_inf = 0, n_ovf = 0, n_gw = 0;
    int w0, s0, r0, o0;
    logic [1:0] last_sel;
    logic [5:0] g_bits [8];
    logic [5:0] rows [8];
    logic [2:0] g_idx, idx;
    logic [7:0] ak [6] = '{8'h44, 8'h43, 8'h42, 8'h42, 8'h41, 8'h41};
    logic [4:0] ac [6] = '{5'h0, 5'h1, 5'h1, 5'h1, 5'h1, 5'h1};
    logic [1:0] ar [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0};

    clp_parser DUT (.clk_sys(clk_sys), .resetn(resetn), .rx_valid(rx_valid),
        .rx_data(rx_data), .lcd_valid(lcd_valid), .lcd_ready(lcd_ready),
        .lcd_data(lcd_data), .glyph_we_q(glyph_we_q), .glyph_idx_q(glyph_idx_q),
        .glyph_row_q(glyph_row_q), .glyph_bits_q(glyph_bits_q),
        .scroll_up_q(scroll_up_q), .info_show_q(info_show_q), .reboot_q(reboot_q),
        .cursor_col_q(cursor_col_q), .cursor_row_q(cursor_row_q),
        .wrap_en_q(wrap_en_q), .scroll_en_q(scroll_en_q), .overflow_q(overflow_q));
    clp_lcd_sink u_sink (.clk_sys(clk_sys), .resetn(resetn), .lcd_valid(lcd_valid),
        .lcd_ready(lcd_ready), .lcd_data(lcd_data), .hold(hold),
        .n_words(n_words), .last_word(last_word));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // pulse counters and glyph row capture
    always @(posedge clk_sys) begin
        if (scroll_up_q) n_scr++;
        if (reboot_q) n_rbt++;
        if (info_show_q) n_inf++;
        if (overflow_q) n_ovf++;
        if (lcd_valid && lcd_ready) last_sel <= {DUT.ctrl_extended_enable_q, DUT.ctrl_reg_select_q};
        if (glyph_we_q) begin
            n_gw++;
            g_bits[glyph_row_q] <= glyph_bits_q;
            g_idx <= glyph_idx_q;
        end
    end

    // expected {extended enable, register select} for a direct-write location
    function automatic logic [1:0] exp_sel(input int loc);
        return (loc == 1) ? 2'b01 : (loc == 2) ? 2'b10 : 2'b00;
    endfunction

    task automatic send(input logic [7:0] b);
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_data <= b;
        @(posedge clk_sys);
        rx_valid <= 1'b0;
    endtask

    task automatic prn(input int n);
        repeat (n) send(8'h20 + 8'($urandom % 96));
    endtask

    task automatic esc(input logic [7:0] k);
        send(8'h1B);
        send(8'h5B);
        send(k);
    endtask

    // wait until the controller port has stayed idle for six edges in a row
    task automatic settle;
        int i;
        int idle;
        idle = 0;
        for (i = 0; i < 2000 && idle < 6; i++) begin
            @(posedge clk_sys);
            idle = lcd_valid ? 0 : idle + 1;
        end
        #1;
    endtask

    task automatic at(input logic [4:0] c, input logic [1:0] r);
        `CHK(cursor_col_q, c)
        `CHK(cursor_row_q, r)
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        mismatches++;
        give_verdict;
    end

    initial begin
        void'($urandom(91));
        rx_valid = 1'b0;
        rx_data = 8'h00;
        hold = 1'b0;
        resetn = 1'b0;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        settle;
        at(5'h0, 2'h0);
        `CHK(scroll_en_q, 1'b1)
        done("reset");
        for (int k = 1; k < 8; k++) send(8'(k));
        settle;
        `CHK(n_words, 16'h0)
        at(5'h0, 2'h0);
        d = 8'h20 + 8'($urandom % 96);
        send(d);
        settle;
        `CHK(last_word, d)
        `CHK(last_sel, exp_sel(1))
        at(5'h1, 2'h0);
        done("print");
        send(8'h0D);
        send(8'h17);
        prn(15);
        settle;
        `CHK(wrap_en_q, 1'b1)
        at(5'hF, 2'h0);
        prn(1);
        settle;
        at(5'h0, 2'h1);
        s0 = n_scr;
        prn(16);
        settle;
        at(5'h0, 2'h1);
        `CHK(n_scr, s0 + 1)
        send(8'h14);
        prn(16);
        settle;
        at(5'h0, 2'h0);
        `CHK(n_scr, s0 + 1)
        send(8'h13);
        done("wrap");
        send(8'h18);
        prn(16);
        settle;
        at(5'h10, 2'h0);
        w0 = n_words;
        prn(1);
        settle;
        `CHK(n_words, 16'(w0))
        send(8'h14);
        prn(1);
        settle;
        `CHK(n_words, 16'(w0))
        at(5'h10, 2'h0);
        send(8'h13);
        esc(8'h44);
        settle;
        at(5'hF, 2'h0);
        send(8'h0D);
        for (int k = 0; k < 6; k++) begin
            esc(ak[k]);
            settle;
            at(ac[k], ar[k]);
        end
        done("arrows");
        idx = 3'($urandom % 8);
        foreach (rows[k]) rows[k] = 6'($urandom % 64);
        rows[1] = 6'h1A;
        rows[2] = 6'h1A;
        s0 = n_gw;
        r0 = n_rbt;
        send(8'h19);
        send({5'h0, idx});
        foreach (rows[k]) send({2'h0, rows[k]});
        settle;
        `CHK(n_gw, s0 + 8)
        `CHK(n_rbt, r0)
        `CHK(g_idx, idx)
        foreach (rows[k]) `CHK(g_bits[k], rows[k])
        w0 = n_words;
        send(8'h80 + {5'h0, idx});
        settle;
        `CHK(n_words, 16'(w0 + 1))
        `CHK(last_word, {5'h0, idx})
        `CHK(last_sel, exp_sel(1))
        at(5'h2, 2'h0);
        done("glyph");
        for (int k = 0; k < 3; k++) begin
            d = (k == 1) ? 8'h16 : 8'($urandom);
            send(8'h1E);
            send(8'(k));
            send(d);
            settle;
            `CHK(last_word, d)
            `CHK(last_sel, exp_sel(k))
            at(5'h2, 2'h0);
        end
        s0 = n_inf;
        send(8'h1F);
        settle;
        `CHK(n_inf, s0 + 1)
        done("direct");
        r0 = n_rbt;
        send(8'h17);
        send(8'h1A);
        send(8'h42);
        settle;
        `CHK(n_rbt, r0)
        `CHK(last_word, 8'h42)
        send(8'h19);
        repeat (9) send(8'h20);
        send(8'h1A);
        send(8'h1A);
        settle;
        `CHK(n_rbt, r0 + 1)
        `CHK(wrap_en_q, 1'b0)
        at(5'h0, 2'h0);
        done("reboot");
        send(8'h17);
        settle;
        o0 = n_ovf;
        s0 = n_words;
        hold <= 1'b1;
        for (int k = 0; k < 90; k++) begin
            @(posedge clk_sys);
            rx_valid <= 1'b1;
            rx_data <= 8'h61;
        end
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        `CHK(lcd_valid, 1'b1)
        hold <= 1'b0;
        settle;
        `CHK(n_ovf > o0, 1'b1)
        `CHK(n_words - s0 + n_ovf - o0, 90)
        done("overflow");
        give_verdict;
    end
endmodule

bind clp_parser clp_monitor u_mon (.clk_sys(clk_sys), .resetn(resetn),
    .lcd_valid(lcd_valid), .lcd_ready(lcd_ready), .lcd_data(lcd_data),
    .glyph_we_q(glyph_we_q), .glyph_row_q(glyph_row_q), .scroll_up_q(scroll_up_q),
    .reboot_q(reboot_q), .overflow_q(overflow_q), .cursor_col_q(cursor_col_q),
    .cursor_row_q(cursor_row_q), .wrap_en_q(wrap_en_q), .scroll_en_q(scroll_en_q));

`default_nettype wire
